// >>> bench/afe_nv_store_model.sv
// afe_nv_store_model: behavioural nonvolatile parameter store.
// Assumes word strobes from the block and one-cycle read latency.
`default_nettype none

module afe_nv_store_model
  import afe_pkg::*;
(
  input wire logic clk,
  input wire logic nv_wr_q,
  input wire logic nv_rd_q,
  input wire logic [3:0] nv_addr_q,
  input wire logic [23:0] nv_wdata_q,
  output var logic [23:0] nv_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] mem [0:12];

  initial begin
    nv_rdata = 24'h5A5A5A;
    for (int i = 0; i < PARAM_DEPTH; i++) mem[i] = 24'h000000;
  end

  // data only valid the cycle after a read strobe, toggling otherwise
  always @(posedge clk) begin
    if (nv_wr_q) mem[nv_addr_q] <= nv_wdata_q;
    nv_rdata <= nv_rd_q ? mem[nv_addr_q] : ~nv_rdata;
  end
endmodule

`default_nettype wire

// >>> bench/test_axis_flag_encoder_interface.sv
// test_axis_flag_encoder_interface: self-checking bench for the block.
// Assumes a 200 MHz clock and the store model on the far side.
`default_nettype none

module test_axis_flag_encoder_interface
  import afe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic plus_overtravel_in = 1'b1, minus_overtravel_in = 1'b1;
  logic home_flag_in = 1'b1, amp_fault_in = 1'b1, nv_present = 1'b0;
  logic enc_cha_in = 1'b0, enc_chb_in = 1'b0, index_channel_in = 1'b0;
  logic enable_polarity_jumper = 1'b0, amp_enable_req = 1'b0;
  logic cmd_dir_neg = 1'b0, capture_clear = 1'b0, save_cmd = 1'b0;
  logic param_wr = 1'b0, param_rd = 1'b0;
  logic [3:0] param_sel = 4'h0;
  logic [23:0] param_wdata = 24'h000000;
  logic [23:0] nv_rdata, param_rdata_q, nv_wdata_q;
  logic amp_enable_dir_out_q, amp_enable_dir_oe_q, move_pos_ok_q;
  logic move_neg_ok_q, home_flag_level_q, fault_active_q, capture_flag_q;
  logic [23:0] enc_count_q, capture_pos_q, comm_phase_a_q, comm_phase_b_q;
  logic comm_valid_q, param_ack_q, param_busy_q, nv_wr_q, nv_rd_q;
  logic [3:0] nv_addr_q;
  logic [23:0] exp_q [$];
  logic [15:0] rnd = 16'h381B;
  logic [23:0] d3, d7, dx, r;
  logic [1:0] ph = 2'h0;
  logic o0;
  int fails = 0;
  int num_checks = 0;
  int cnt;

  always #2.5 clk = ~clk;

  afe_axis_flag_encoder_interface afe_axis_flag_encoder_interface_inst (.*);
  afe_nv_store_model afe_nv_store_model_inst (.*);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [23:0] g, input logic [23:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic chb(input logic g, input logic e, input string m);
    chk({23'h0, g}, {23'h0, e}, m);
  endtask

  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // writes answer with zero data, reads with the word
  task automatic acc(input logic wr, input logic [3:0] s,
                     input logic [23:0] d, input logic [23:0] e);
    @(posedge clk);
    param_wr <= wr;
    param_rd <= ~wr;
    param_sel <= s;
    param_wdata <= d;
    exp_q.push_back(wr ? 24'h000000 : e);
    @(posedge clk);
    param_wr <= 1'b0;
    param_rd <= 1'b0;
  endtask

  task automatic wp(input logic [3:0] s, input logic [23:0] d);
    acc(1'b1, s, d, 24'h000000);
  endtask

  task automatic rp(input logic [3:0] s, input logic [23:0] e);
    acc(1'b0, s, 24'h000000, e);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (param_busy_q !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin
      fails++;
      complete_run();
    end
  endtask

  task automatic pins(input logic p, input logic m, input logic h,
                      input logic f);
    @(posedge clk);
    plus_overtravel_in <= p;
    minus_overtravel_in <= m;
    home_flag_in <= h;
    amp_fault_in <= f;
    settle();
  endtask

  task automatic clr();
    @(posedge clk);
    capture_clear <= 1'b1;
    @(posedge clk);
    capture_clear <= 1'b0;
    settle();
  endtask

  // eight quadrature edges forward, count change returned
  task automatic meas(input logic [23:0] m, output logic [23:0] d);
    logic [23:0] c;
    wp(4'h0, m);
    settle();
    c = enc_count_q;
    for (int i = 0; i < 8; i++) begin
      ph = ph + 2'h1;
      @(posedge clk);
      enc_cha_in <= ph[1] ^ ph[0];
      enc_chb_in <= ph[1];
      repeat (4) @(posedge clk);
    end
    settle();
    d = enc_count_q - c;
  endtask

  always @(posedge clk) begin
    if (param_ack_q === 1'b1) begin
      if (exp_q.size() == 0) chk(24'h1, 24'h0, "stray ack");
      else chk(param_rdata_q, exp_q.pop_front(), "rdata");
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    wait_idle();
    for (int i = 0; i < 13; i++) rp(4'(i), PARAM_RST[i]);
    rp(4'hD, 24'h000000);
    rnd = lfsr(rnd);
    r = {8'h00, rnd};
    wp(4'h4, r);
    rp(4'h4, r);
    wp(4'h5, 24'h000001);
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    chb(move_pos_ok_q & move_neg_ok_q, 1'b1, "held low");
    pins(1'b0, 1'b1, 1'b1, 1'b1);
    chb(move_pos_ok_q, 1'b0, "minus open");
    chb(move_neg_ok_q, 1'b1, "minus open neg");
    pins(1'b1, 1'b0, 1'b1, 1'b1);
    chb(move_pos_ok_q, 1'b1, "plus open pos");
    chb(move_neg_ok_q, 1'b0, "plus open");
    pins(1'b1, 1'b1, 1'b1, 1'b1);
    wp(4'h8, 24'h02C000);
    settle();
    chb(move_pos_ok_q & move_neg_ok_q, 1'b1, "limits off");
    wp(4'h8, FLAG_ADDR1);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    chb(fault_active_q, 1'b1, "low fault");
    chb(move_pos_ok_q, 1'b0, "fault stop");
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    chb(fault_active_q, 1'b0, "open fault");
    wp(4'h8, 24'h80C000);
    settle();
    chb(fault_active_q, 1'b1, "high fault");
    wp(4'h8, FLAG_ADDR1);
    amp_enable_req <= 1'b1;
    settle();
    chb(amp_enable_dir_oe_q, 1'b1, "enable conducts");
    chb(amp_enable_dir_out_q, 1'b0, "pin data");
    enable_polarity_jumper <= 1'b1;
    settle();
    chb(amp_enable_dir_oe_q, 1'b0, "enable inverted");
    enable_polarity_jumper <= 1'b0;
    wp(4'h8, 24'h01C000);
    settle();
    o0 = amp_enable_dir_oe_q;
    cmd_dir_neg <= 1'b1;
    settle();
    chb(o0, 1'b0, "direction pos");
    chb(amp_enable_dir_oe_q, 1'b1, "direction");
    wp(4'h8, FLAG_ADDR1);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chb(home_flag_level_q, 1'b0, "home closed");
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    chb(home_flag_level_q, 1'b1, "home open");
    meas(24'h000003, d3);
    meas(24'h000007, d7);
    chb(d3 == 24'h8 || d3 == 24'hFFFFF8, 1'b1, "x4 size");
    chk(d3 + d7, 24'h0, "sense");
    meas(24'h000001, dx);
    chk(dx << 2, d3, "x1");
    meas(24'h000002, dx);
    chk(dx << 1, d3, "x2");
    wp(4'h1, 24'h000001);
    meas(24'h000007, dx);
    chk(dx, d7, "no filter");
    wp(4'h1, 24'h000000);
    wp(4'h0, 24'h000000);
    settle();
    r[15:0] = enc_count_q[15:0];
    for (int i = 0; i < 4; i++) begin
      enc_cha_in <= 1'b1;
      repeat (4) @(posedge clk);
      enc_cha_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    settle();
    chk({8'h0, enc_count_q[15:0] - r[15:0]}, 24'h4, "pulse dir");
    wp(4'h0, 24'h000007);
    clr();
    index_channel_in <= 1'b1;
    settle();
    chb(capture_flag_q, 1'b1, "index");
    chk(capture_pos_q, enc_count_q, "cap pos");
    index_channel_in <= 1'b0;
    clr();
    chb(capture_flag_q, 1'b0, "cleared");
    index_channel_in <= 1'b1;
    @(posedge clk);
    index_channel_in <= 1'b0;
    settle();
    chb(capture_flag_q, 1'b0, "glitch");
    wp(4'h2, 24'h000005);
    clr();
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chb(capture_flag_q, 1'b0, "no fall");
    pins(1'b0, 1'b0, 1'b1, 1'b1);
    chb(capture_flag_q, 1'b1, "home rise");
    clr();
    wp(4'h2, 24'h000006);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    chb(capture_flag_q, 1'b1, "home fall");
    wp(4'h6, 24'h000001);
    wp(4'h7, OUT_PAIR1_ADDR);
    settle();
    chb(comm_valid_q, 1'b1, "comm");
    chk((comm_phase_b_q - comm_phase_a_q) & 24'hFFF, 24'h550, "85");
    wp(4'hC, 24'h0000AB);
    settle();
    chk((comm_phase_b_q - comm_phase_a_q) & 24'hFFF, 24'hAB0, "171");
    wp(4'hA, 24'h000003);
    meas(24'h000003, dx);
    chk(comm_phase_a_q, 24'h000018, "mult");
    wp(4'h7, OUT_SINGLE1_ADDR);
    wp(4'h5, 24'h000002);
    settle();
    chb(comm_valid_q | move_pos_ok_q, 1'b0, "inactive");
    save_cmd <= 1'b1;
    @(posedge clk);
    save_cmd <= 1'b0;
    cnt = 0;
    repeat (40) @(posedge clk) if (nv_wr_q === 1'b1) cnt++;
    chk(24'(cnt), 24'hD, "save words");
    wait_idle();
    wp(4'h4, 24'h000000);
    @(posedge clk);
    nrst <= 1'b0;
    nv_present <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_idle();
    rp(4'h4, {8'h00, rnd});
    rp(4'h5, 24'h000002);
    settle();
    chk(24'(exp_q.size()), 24'h0, "missing ack");
    complete_run();
  end
endmodule

`default_nettype wire

// >>> verilog/afe_axis_flag_encoder_interface.sv
// afe_axis_flag_encoder_interface: limits, home, fault, amplifier enable,
// encoder decode, capture, commutation phase and parameter store.
// Assumes all pin inputs are asynchronous and the store replies one cycle
// after a read strobe.
// Function
// [R1] motion needs limit input held low
// [R2] each limit blocks one travel direction
// [R3] limit checking can be switched off
// [R4] open-collector enable, jumper polarity, low-true default
// [R5] enable pin becomes direction in direction mode
// [R6] home flag open reads one
// [R7] home edge polarity set by capture words
// [R8] fault polarity programmable, default active low
// [R9] unconnected fault input means no fault
// [R10] decode x1, x2, x4 and pulse-direction
// [R11] decode value 7 is reversed x4
// [R12] delay filter on unless disable set
// [R13] capture source and edge, default rising index
// [R14] flag select zero picks home flag
// [R15] five parameter words per encoder
// [R16] decode 7 to 3 reverses count sense
// [R17] activation word one enables the motor
// [R18] output word names lower output pair
// [R19] feedback word names phase register address
// [R20] commutation cycle as count and multiplier
// [R21] phase spacing in 1/256 cycle
// [R22] save writes store, reset reloads it
// [R23] host reads and writes parameters by name
// [R24] pin inputs pass two flops first
`default_nettype none

module afe_axis_flag_encoder_interface
  import afe_pkg::*;
#(
  parameter int CNT_W = 24,
  parameter int ENC_ID = 1,
  parameter logic [23:0] ENC_PHASE_ADDR = ENC1_PHASE_ADDR,
  parameter logic [23:0] OUT_PAIR_ADDR = OUT_PAIR1_ADDR
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic plus_overtravel_in,
  input wire logic minus_overtravel_in,
  input wire logic home_flag_in,
  input wire logic amp_fault_in,
  input wire logic enc_cha_in,
  input wire logic enc_chb_in,
  input wire logic index_channel_in,
  input wire logic enable_polarity_jumper,
  input wire logic nv_present,
  input wire logic amp_enable_req,
  input wire logic cmd_dir_neg,
  input wire logic capture_clear,
  input wire logic param_wr,
  input wire logic param_rd,
  input wire logic [3:0] param_sel,
  input wire logic [23:0] param_wdata,
  input wire logic save_cmd,
  input wire logic [23:0] nv_rdata,
  output var logic amp_enable_dir_out_q,
  output var logic amp_enable_dir_oe_q,
  output var logic move_pos_ok_q,
  output var logic move_neg_ok_q,
  output var logic home_flag_level_q,
  output var logic fault_active_q,
  output var logic [CNT_W-1:0] enc_count_q,
  output var logic [CNT_W-1:0] capture_pos_q,
  output var logic capture_flag_q,
  output var logic [23:0] comm_phase_a_q,
  output var logic [23:0] comm_phase_b_q,
  output var logic comm_valid_q,
  output var logic [23:0] param_rdata_q,
  output var logic param_ack_q,
  output var logic param_busy_q,
  output var logic nv_wr_q,
  output var logic nv_rd_q,
  output var logic [3:0] nv_addr_q,
  output var logic [23:0] nv_wdata_q
);

  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // parameter words
  logic [23:0] param_q [0:PARAM_DEPTH-1];
  logic [3:0] dec_sel;
  logic filt_dis;
  logic [3:0] trg;
  logic [1:0] fsel;
  logic activ;
  logic comm_on;
  logic [23:0] fm;
  logic [23:0] mult;
  logic [23:0] counts;
  logic [7:0] phase;
  logic fb_match;
  logic out_ok;
  assign dec_sel = param_q[P_DECODE][3:0];
  assign filt_dis = param_q[P_FILTER][0];
  assign trg = param_q[P_TRIG][3:0];
  assign fsel = param_q[P_FLAG_SEL][1:0];
  assign activ = param_q[P_ACTIVATE] == PARAM_ONE; // [R17]
  assign comm_on = param_q[P_COMM_ON] == PARAM_ONE;
  assign fm = param_q[P_FLAG_MODE];
  assign mult = param_q[P_CYC_MULT];
  assign counts = param_q[P_CYC_COUNTS];
  assign phase = param_q[P_PHASE][7:0];
  assign fb_match = param_q[P_FB_ADDR] == ENC_PHASE_ADDR; // [R19]
  assign out_ok = param_q[P_OUT_ADDR] == OUT_PAIR_ADDR; // [R18]

  // pin conditioning
  logic [IN_N-1:0] pins;
  logic [IN_N-1:0] filt_en;
  logic [IN_N-1:0] cin;
  assign pins = {nv_present, enable_polarity_jumper, index_channel_in,
                 enc_chb_in, enc_cha_in, amp_fault_in, home_flag_in,
                 minus_overtravel_in, plus_overtravel_in};
  assign filt_en = {2'b00, {3{~filt_dis}}, 4'h0}; // [R12]

  afe_input_cond #(.W(IN_N), .RST_VAL(IN_RST_VAL)) u_cond ( // [R24]
    .clk(clk),
    .rst_n(rst_n_q),
    .din(pins),
    .filt_en(filt_en),
    .dout_q(cin)
  );

  // limits, fault and amplifier enable
  logic lim_dis;
  logic dir_mode;
  logic jumper;
  logic fault_d;
  logic pos_ok_d;
  logic neg_ok_d;
  logic amp_en;
  logic conduct_d;
  assign lim_dis = fm[FM_LIM_DIS];
  assign dir_mode = fm[FM_DIR_MODE];
  assign jumper = cin[IN_JUMPER];
  assign fault_d = fm[FM_FAULT_POL] ? cin[IN_FAULT] : ~cin[IN_FAULT]; // [R8] [R9]
  assign pos_ok_d = activ & ~fault_d & (lim_dis | ~cin[IN_MINUS]); // [R1] [R2] [R3]
  assign neg_ok_d = activ & ~fault_d & (lim_dis | ~cin[IN_PLUS]); // [R1] [R2] [R3]
  assign amp_en = activ & amp_enable_req & ~fault_d;
  assign conduct_d = dir_mode ? (cmd_dir_neg ^ jumper) // [R5]
                              : (amp_en ^ jumper); // [R4]

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      move_pos_ok_q <= 1'b0;
      move_neg_ok_q <= 1'b0;
      fault_active_q <= 1'b0;
      home_flag_level_q <= 1'b1;
      amp_enable_dir_out_q <= 1'b0;
      amp_enable_dir_oe_q <= 1'b0;
    end else begin
      move_pos_ok_q <= pos_ok_d;
      move_neg_ok_q <= neg_ok_d;
      fault_active_q <= fault_d;
      home_flag_level_q <= cin[IN_HOME]; // [R6]
      amp_enable_dir_out_q <= 1'b0;
      amp_enable_dir_oe_q <= conduct_d;
    end
  end

  // encoder decode
  logic a_p_q;
  logic b_p_q;
  logic a_ch;
  logic b_ch;
  logic quad_up;
  logic step;
  logic up;
  assign a_ch = cin[IN_CHA] ^ a_p_q;
  assign b_ch = cin[IN_CHB] ^ b_p_q;
  assign quad_up = cin[IN_CHA] ^ b_p_q;
  // in x2 and x4 a double change is a lost state and is not counted
  assign step = (dec_sel[1:0] == DEC_PULSE_DIR) ? (a_ch & cin[IN_CHA]) :
                (dec_sel[1:0] == DEC_X1) ? (a_ch & (cin[IN_CHA] == quad_up)) :
                (dec_sel[1:0] == DEC_X2) ? (a_ch & ~b_ch) :
                ((a_ch ^ b_ch)); // [R10]
  assign up = ((dec_sel[1:0] == DEC_PULSE_DIR) ? ~cin[IN_CHB] : quad_up) ^
              dec_sel[DEC_REV]; // [R11] [R16]

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      a_p_q <= 1'b0;
      b_p_q <= 1'b0;
      enc_count_q <= '0;
    end else begin
      a_p_q <= cin[IN_CHA];
      b_p_q <= cin[IN_CHB];
      if (step) begin
        enc_count_q <= up ? enc_count_q + 1'b1 : enc_count_q - 1'b1;
      end
    end
  end

  // position capture
  logic flag_sig;
  logic trig_sig;
  logic trig_p_q;
  logic cap_ev;
  logic cap_take;
  assign flag_sig = (fsel == FSEL_HOME) ? cin[IN_HOME] : // [R14]
                    (fsel == FSEL_PLUS) ? cin[IN_PLUS] :
                    (fsel == FSEL_MINUS) ? cin[IN_MINUS] : cin[IN_FAULT];
  assign trig_sig = (trg[3:2] == SRC_INDEX) ? cin[IN_INDEX] :
                    (trg[3:2] == SRC_FLAG) ? flag_sig :
                    (trg[3:2] == SRC_AND) ? (cin[IN_INDEX] & flag_sig) :
                    (cin[IN_INDEX] & ~flag_sig); // [R13]
  assign cap_ev = (trg[TRG_RISE] & trig_sig & ~trig_p_q) |
                  (trg[TRG_FALL] & ~trig_sig & trig_p_q); // [R7] [R13]
  // first event is held until software clears the flag
  assign cap_take = cap_ev & (~capture_flag_q | capture_clear);

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      trig_p_q <= 1'b0;
      capture_flag_q <= 1'b0;
      capture_pos_q <= '0;
    end else begin
      trig_p_q <= trig_sig;
      capture_flag_q <= cap_ev | (capture_flag_q & ~capture_clear);
      if (cap_take) begin
        capture_pos_q <= enc_count_q;
      end
    end
  end

  // commutation phase position in multiplied counts, wrapped at a cycle
  logic comm_run;
  logic comm_step;
  logic [24:0] u_up_sum;
  logic [23:0] u_up;
  logic [23:0] u_dn;
  logic [31:0] prod;
  logic [23:0] off;
  logic [24:0] b_sum;
  logic [23:0] b_pos;
  assign comm_run = activ & comm_on;
  assign comm_step = step & comm_run & fb_match;
  assign u_up_sum = {1'b0, comm_phase_a_q} + {1'b0, mult}; // [R20]
  assign u_up = (u_up_sum >= {1'b0, counts}) ?
                24'(u_up_sum - {1'b0, counts}) : u_up_sum[23:0];
  assign u_dn = (comm_phase_a_q < mult) ?
                24'(comm_phase_a_q + counts - mult) :
                24'(comm_phase_a_q - mult);
  assign prod = {24'h000000, phase} * {8'h00, counts}; // [R21]
  assign off = prod[31:8];
  assign b_sum = {1'b0, comm_phase_a_q} + {1'b0, off};
  assign b_pos = (b_sum >= {1'b0, counts}) ?
                 24'(b_sum - {1'b0, counts}) : b_sum[23:0];

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      comm_phase_a_q <= '0;
      comm_phase_b_q <= '0;
      comm_valid_q <= 1'b0;
    end else begin
      comm_valid_q <= comm_run & fb_match & out_ok;
      comm_phase_b_q <= comm_run ? b_pos : '0;
      if (!comm_run) begin
        comm_phase_a_q <= '0;
      end else if (comm_step) begin
        comm_phase_a_q <= up ? u_up : u_dn;
      end
    end
  end

  // parameter access and store sequencing
  afe_state_type st_q;
  afe_state_type st_d;
  logic [3:0] idx_q;
  logic [1:0] ph_q;
  logic [1:0] boot_q;
  logic idle;
  logic sel_ok;
  logic ld_wr;
  logic host_wr;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [23:0] wr_data;
  logic idx_last;
  assign idle = st_q == ST_IDLE;
  assign sel_ok = param_sel < PARAM_N; // [R15]
  assign ld_wr = (st_q == ST_LOAD) && (ph_q == PH_TAKE); // [R22]
  assign host_wr = param_wr & idle & sel_ok; // [R23]
  assign wr_en = ld_wr | host_wr;
  assign wr_idx = ld_wr ? idx_q : param_sel;
  assign wr_data = ld_wr ? nv_rdata : param_wdata;
  assign idx_last = idx_q == PARAM_LAST;

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_BOOT: begin
        if (boot_q == BOOT_WAIT) begin
          st_d = cin[IN_NVP] ? ST_LOAD : ST_IDLE;
        end
      end
      ST_LOAD: begin
        if (ld_wr && idx_last) begin
          st_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (save_cmd) begin
          st_d = ST_SAVE; // [R22]
        end
      end
      ST_SAVE: begin
        if (idx_last) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (int i = 0; i < PARAM_DEPTH; i++) begin
        param_q[i] <= PARAM_RST[i];
      end
    end else if (wr_en) begin
      param_q[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= ST_BOOT;
      boot_q <= 2'h0;
      idx_q <= 4'h0;
      ph_q <= PH_ISSUE;
    end else begin
      st_q <= st_d;
      if (st_q == ST_BOOT) begin
        boot_q <= boot_q + 2'h1;
      end
      if (st_d != st_q) begin
        idx_q <= 4'h0;
        ph_q <= PH_ISSUE;
      end else if (st_q == ST_SAVE || ld_wr) begin
        idx_q <= idx_q + 4'h1;
        ph_q <= PH_ISSUE;
      end else if (st_q == ST_LOAD) begin
        ph_q <= ph_q + 2'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nv_wr_q <= 1'b0;
      nv_rd_q <= 1'b0;
      nv_addr_q <= 4'h0;
      nv_wdata_q <= '0;
      param_rdata_q <= '0;
      param_ack_q <= 1'b0;
      param_busy_q <= 1'b1;
    end else begin
      nv_wr_q <= st_q == ST_SAVE;
      nv_rd_q <= (st_q == ST_LOAD) && (ph_q == PH_ISSUE);
      nv_addr_q <= idx_q;
      nv_wdata_q <= param_q[idx_q];
      param_ack_q <= (param_rd | param_wr) & idle; // [R23]
      param_rdata_q <= (param_rd && sel_ok) ? param_q[param_sel] : '0;
      param_busy_q <= st_d != ST_IDLE;
    end
  end

  a_pos_limit_block: assert property (@(posedge clk) disable iff (!rst_n_q) // [R2]
    (!lim_dis && cin[IN_MINUS]) |=> !move_pos_ok_q)
    else $error("positive travel allowed with minus limit open");
  a_neg_limit_block: assert property (@(posedge clk) disable iff (!rst_n_q) // [R1]
    (!lim_dis && cin[IN_PLUS]) |=> !move_neg_ok_q)
    else $error("negative travel allowed with plus limit open");
  a_limit_bypass: assert property (@(posedge clk) disable iff (!rst_n_q) // [R3]
    (lim_dis && activ && !fault_d) |=> (move_pos_ok_q && move_neg_ok_q))
    else $error("disabled limits still block motion");
  a_enable_low_true: assert property (@(posedge clk) disable iff (!rst_n_q) // [R4]
    (!dir_mode && !jumper) |=> (amp_enable_dir_oe_q == $past(amp_en)))
    else $error("enable output not conducting when enabled");
  a_dir_mode_out: assert property (@(posedge clk) disable iff (!rst_n_q) // [R5]
    dir_mode |=> (amp_enable_dir_oe_q == $past(cmd_dir_neg ^ jumper)))
    else $error("direction output wrong in direction mode");
  a_home_level: assert property (@(posedge clk) disable iff (!rst_n_q) // [R6]
    cin[IN_HOME] [*2] |-> home_flag_level_q)
    else $error("open home switch not read as one");
  a_fault_idle: assert property (@(posedge clk) disable iff (!rst_n_q) // [R9]
    (!fm[FM_FAULT_POL] && cin[IN_FAULT]) |=> !fault_active_q)
    else $error("undriven fault input seen as fault");
  a_fault_gate: assert property (@(posedge clk) disable iff (!rst_n_q) // [R8]
    fault_active_q |-> !($past(amp_en) || move_pos_ok_q || move_neg_ok_q))
    else $error("fault did not shut down action");
  a_x4_reverse: assert property (@(posedge clk) disable iff (!rst_n_q) // [R16]
    (dec_sel == 4'h7 && (a_ch ^ b_ch) && quad_up)
      |=> (enc_count_q == $past(enc_count_q) - 1'b1))
    else $error("reversed x4 decode counted the wrong way");
  a_capture_set: assert property (@(posedge clk) disable iff (!rst_n_q) // [R13]
    (cap_ev && !capture_flag_q) |=> (capture_flag_q &&
      capture_pos_q == $past(enc_count_q)))
    else $error("capture event not latched");
  a_load_bounded: assert property (@(posedge clk) disable iff (!rst_n_q) // [R22]
    (st_q == ST_LOAD && $past(st_q) != ST_LOAD) |-> ##[1:45] idle)
    else $error("store reload did not finish");
  a_param_reply: assert property (@(posedge clk) disable iff (!rst_n_q) // [R23]
    (param_rd && idle && param_sel == 4'h0) |=>
      (param_ack_q && param_rdata_q == $past(param_q[P_DECODE])))
    else $error("parameter read not answered");

endmodule

`default_nettype wire

// >>> verilog/afe_input_cond.sv
// afe_input_cond: two-flop synchroniser plus optional delay filter for a
// vector of asynchronous pin inputs.
// Assumes rst_n is already synchronous to clk.
`default_nettype none

module afe_input_cond #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  input wire logic [W-1:0] filt_en,
  output var logic [W-1:0] dout_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] hold_q;
  logic [W-1:0] agree;
  logic [W-1:0] dout_d;

  // filtered bits move only after two agreeing synchronised samples
  assign agree = ~(sync_q ^ hold_q);
  assign dout_d = ((~filt_en | agree) & sync_q) |
                  ((filt_en & ~agree) & dout_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
      hold_q <= RST_VAL;
      dout_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      hold_q <= sync_q;
      dout_q <= dout_d;
    end
  end

endmodule

`default_nettype wire

// >>> verilog/afe_pkg.sv
// afe_pkg: constants, parameter map and reset values for the axis flag
// and encoder interface block.
// Assumes one motor and one encoder channel per instance.
`default_nettype none

package afe_pkg;

  // conditioned input vector bit positions
  localparam int IN_PLUS = 0;
  localparam int IN_MINUS = 1;
  localparam int IN_HOME = 2;
  localparam int IN_FAULT = 3;
  localparam int IN_CHA = 4;
  localparam int IN_CHB = 5;
  localparam int IN_INDEX = 6;
  localparam int IN_JUMPER = 7;
  localparam int IN_NVP = 8;
  localparam int IN_N = 9;
  // idle pin levels: opto inputs read high when nothing drives them
  localparam logic [8:0] IN_RST_VAL = 9'h00F;

  // parameter word map: five encoder words, then the motor words
  localparam int PARAM_W = 24;
  localparam int PARAM_DEPTH = 13;
  localparam logic [3:0] PARAM_N = 4'hD;
  localparam logic [3:0] PARAM_LAST = 4'hC;
  localparam int ENC_GROUP = 5;
  localparam int ENC_MAX = 16;
  localparam int P_DECODE = 0;
  localparam int P_FILTER = 1;
  localparam int P_TRIG = 2;
  localparam int P_FLAG_SEL = 3;
  localparam int P_ENC_SPARE = 4;
  localparam int P_ACTIVATE = 5;
  localparam int P_COMM_ON = 6;
  localparam int P_OUT_ADDR = 7;
  localparam int P_FLAG_MODE = 8;
  localparam int P_FB_ADDR = 9;
  localparam int P_CYC_MULT = 10;
  localparam int P_CYC_COUNTS = 11;
  localparam int P_PHASE = 12;
  localparam logic [23:0] PARAM_ONE = 24'h000001;

  // addresses seen by the parameter words
  localparam logic [23:0] FLAG_ADDR1 = 24'h00C000;
  localparam logic [23:0] ENC1_PHASE_ADDR = 24'h00C001;
  localparam logic [23:0] OUT_PAIR1_ADDR = 24'h00C002;
  localparam logic [23:0] OUT_SINGLE1_ADDR = 24'h00C003;

  // flag address and mode word fields
  localparam int FM_DIR_MODE = 16;
  localparam int FM_LIM_DIS = 17;
  localparam int FM_FAULT_POL = 23;

  // decode word: [1:0] mode, [2] reverse sense
  localparam logic [1:0] DEC_PULSE_DIR = 2'h0;
  localparam logic [1:0] DEC_X1 = 2'h1;
  localparam logic [1:0] DEC_X2 = 2'h2;
  localparam logic [1:0] DEC_X4 = 2'h3;
  localparam int DEC_REV = 2;

  // capture word: [0] rising, [1] falling, [3:2] source
  localparam int TRG_RISE = 0;
  localparam int TRG_FALL = 1;
  localparam logic [1:0] SRC_INDEX = 2'h0;
  localparam logic [1:0] SRC_FLAG = 2'h1;
  localparam logic [1:0] SRC_AND = 2'h2;
  localparam logic [1:0] SRC_AND_NOT = 2'h3;

  localparam logic [1:0] FSEL_HOME = 2'h0;
  localparam logic [1:0] FSEL_PLUS = 2'h1;
  localparam logic [1:0] FSEL_MINUS = 2'h2;
  localparam logic [1:0] FSEL_FAULT = 2'h3;

  localparam logic [23:0] PARAM_RST [0:12] = '{
    24'h000007, 24'h000000, 24'h000001, 24'h000000, 24'h000000,
    24'h000000, 24'h000000, OUT_SINGLE1_ADDR, FLAG_ADDR1,
    ENC1_PHASE_ADDR, 24'h000001, 24'h001000, 24'h000055
  };

  // cycles spent after reset release before the store strap is trusted
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [1:0] PH_ISSUE = 2'h0;
  localparam logic [1:0] PH_WAIT = 2'h1;
  localparam logic [1:0] PH_TAKE = 2'h2;

  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_LOAD = 2'b01,
    ST_IDLE = 2'b11,
    ST_SAVE = 2'b10
  } afe_state_type;

endpackage

`default_nettype wire
